// >>> spio_pkg.sv
// Constants, types and timing for the servo pulse input/output block
// Overview of operation
// - Four receiver inputs are each timed, giving one pulse width per channel.
// - Every input has its own edge capture and its own one-cycle event output.
// - Three free-running generators make servo pulses from a period and a duty width.
// - Output pulse widths are held between one and two milliseconds.
// - Output pulses repeat about every twenty-five milliseconds.
// - Servo lines idle low and are high only during the pulse.
// - The gap between output pulses is never removed or shortened.
// - New duty values are taken at most about forty times a second.
// - The fourth input is a command channel, reported but never sent to a servo.
// - No wire joins inputs to outputs; manual mode copies measured widths at input events, stale clearing with each event so no capture is skipped.
package spio_pkg;
   localparam int unsigned CLK_HZ       = 40_000_000;
   localparam int unsigned US_PER_TICK  = 1;
   localparam int unsigned TICK_DIV     = CLK_HZ / 1_000_000 * US_PER_TICK;
   localparam int unsigned PULSE_MIN_US = 1000;
   localparam int unsigned PULSE_MAX_US = 2000;
   localparam int unsigned PERIOD_US    = 25000;
   localparam int unsigned STALE_PERIODS = 4;
   localparam int unsigned STALE_US     = PERIOD_US * STALE_PERIODS;
   localparam int unsigned N_IN         = 4;
   localparam int unsigned N_OUT        = 3;
   localparam int unsigned CMD_CH       = 3;
   localparam int unsigned W            = 16;
   localparam int unsigned SW           = 17;

   localparam logic [5:0]    DIV_LAST    = 6'(TICK_DIV - 1);
   localparam logic [W-1:0]  MIN_W       = W'(PULSE_MIN_US);
   localparam logic [W-1:0]  MAX_W       = W'(PULSE_MAX_US);
   localparam logic [W-1:0]  PERIOD_LAST = W'(PERIOD_US - 1);
   localparam logic [W-1:0]  WIDTH_RST   = W'((PULSE_MIN_US + PULSE_MAX_US) / 2);
   localparam logic [SW-1:0] STALE_LAST  = SW'(STALE_US - 1);
   localparam logic [W-1:0]  CNT_ZERO    = 16'h0000;

   typedef logic [W-1:0] spio_width_t;

   typedef struct packed {
      logic        event_p;
      logic        stale;
      spio_width_t width;
   } spio_meas_t;

   // Clamp a commanded width into the legal servo range
   function automatic spio_width_t spio_clamp(input spio_width_t w);
      if (w < MIN_W)
         return MIN_W;
      else if (w > MAX_W)
         return MAX_W;
      else
         return w;
   endfunction
endpackage

// >>> spio_capture.sv
// One receiver channel: rising-to-falling width timer with stale watchdog
`timescale 1ns/100ps
module spio_capture
   import spio_pkg::*;
(
   // Clock and reset
   input  wire logic       clock_in,
   input  wire logic       rst_in,
   // Microsecond tick and pin
   input  wire logic       tick_in,
   input  wire logic       pulse_in,
   // Result
   output spio_meas_t      meas_out
);
   logic        level_reg;
   logic        high_reg;
   spio_width_t cnt_reg;
   logic [SW-1:0] idle_reg;

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in)
         level_reg <= 1'b0;
      else
         level_reg <= pulse_in;
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         high_reg <= 1'b0;
         cnt_reg  <= CNT_ZERO;
      end else if (pulse_in && !level_reg) begin
         high_reg <= 1'b1;
         cnt_reg  <= CNT_ZERO;
      end else if (!pulse_in && level_reg) begin
         high_reg <= 1'b0;
      end else if (high_reg && tick_in && cnt_reg != {W{1'b1}}) begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         meas_out <= '{event_p: 1'b0, stale: 1'b1, width: WIDTH_RST};
      end else begin
         meas_out.event_p <= !pulse_in && level_reg && high_reg;
         if (!pulse_in && level_reg && high_reg) begin
            meas_out.width <= cnt_reg;
            meas_out.stale <= 1'b0;
         // stale after timeout
         // A finished pulse beats the timeout: the saturated watchdog would re-set it every tick
         end else if (tick_in && idle_reg == STALE_LAST) begin
            meas_out.stale <= 1'b1;
         end
      end
   end

   // Watchdog restarts on every complete pulse
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in)
         idle_reg <= '0;
      else if (!pulse_in && level_reg && high_reg)
         idle_reg <= '0;
      else if (tick_in && idle_reg != STALE_LAST)
         idle_reg <= idle_reg + 1'b1;
   end
endmodule

// >>> spio_top.sv
// Servo pulse I/O: four measured receiver inputs, three servo generators
`timescale 1ns/100ps
module spio_top
   import spio_pkg::*;
(
   // Clock and reset
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   // Receiver pins
   input  wire logic        radio_in_ch_a_in,
   input  wire logic        radio_in_ch_b_in,
   input  wire logic        radio_in_ch_c_in,
   input  wire logic        radio_cmd_in,
   // Firmware control
   input  wire logic        manual_mode_in,
   input  wire spio_width_t duty_a_in,
   input  wire spio_width_t duty_b_in,
   input  wire spio_width_t duty_c_in,
   // Measurement results
   output spio_width_t      width_a_out,
   output spio_width_t      width_b_out,
   output spio_width_t      width_c_out,
   output spio_width_t      cmd_width_out,
   output logic [N_IN-1:0]  capture_event_out,
   output logic [N_IN-1:0]  stale_out,
   // Servo pins
   output logic             servo_gen_high_a,
   output logic             servo_out_ch_b,
   output logic             servo_out_ch_c
);
   logic [5:0]        div_reg;
   logic              tick_reg;
   spio_width_t       period_reg;
   logic              frame_end;
   spio_meas_t        meas [N_IN];
   logic [N_IN-1:0]   pins;
   spio_width_t       duty_reg [N_OUT];
   spio_width_t       fw_duty [N_OUT];
   spio_width_t       pend_reg [N_OUT];
   logic [N_OUT-1:0]  high_next;
   logic [N_OUT-1:0]  high_reg;

   assign pins    = {radio_cmd_in, radio_in_ch_c_in, radio_in_ch_b_in, radio_in_ch_a_in};
   assign fw_duty = '{duty_a_in, duty_b_in, duty_c_in};

   // Microsecond tick enable
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         div_reg  <= '0;
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= (div_reg == DIV_LAST);
         div_reg  <= (div_reg == DIV_LAST) ? 6'h00 : div_reg + 1'b1;
      end
   end

   genvar i;
   generate
      for (i = 0; i < N_IN; i++) begin : g_cap
         spio_capture u_cap (
            .clock_in (clock_in),
            .rst_in   (rst_in),
            .tick_in  (tick_reg),
            .pulse_in (pins[i]),
            .meas_out (meas[i])
         );
      end
   endgenerate

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         width_a_out       <= WIDTH_RST;
         width_b_out       <= WIDTH_RST;
         width_c_out       <= WIDTH_RST;
         cmd_width_out     <= WIDTH_RST;
         capture_event_out <= '0;
         stale_out         <= '1;
      end else begin
         width_a_out   <= meas[0].width;
         width_b_out   <= meas[1].width;
         width_c_out   <= meas[2].width;
         cmd_width_out <= meas[CMD_CH].width;
         for (int k = 0; k < N_IN; k++) begin
            capture_event_out[k] <= meas[k].event_p;
            stale_out[k]         <= meas[k].stale;
         end
      end
   end

   assign frame_end = tick_reg && (period_reg == PERIOD_LAST);
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in)
         period_reg <= CNT_ZERO;
      else if (tick_reg)
         period_reg <= (period_reg == PERIOD_LAST) ? CNT_ZERO : period_reg + 1'b1;
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         for (int k = 0; k < N_OUT; k++)
            pend_reg[k] <= WIDTH_RST;
      end else begin
         for (int k = 0; k < N_OUT; k++) begin
            if (manual_mode_in) begin
               if (meas[k].event_p && !meas[k].stale)
                  pend_reg[k] <= meas[k].width;
            end else begin
               pend_reg[k] <= fw_duty[k];
            end
         end
      end
   end

   // duty loaded once per frame only
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         for (int k = 0; k < N_OUT; k++)
            duty_reg[k] <= WIDTH_RST;
      end else if (frame_end) begin
         for (int k = 0; k < N_OUT; k++)
            duty_reg[k] <= spio_clamp(pend_reg[k]);
      end
   end

   // high only while count below duty
   always_comb begin
      for (int k = 0; k < N_OUT; k++)
         high_next[k] = (period_reg < duty_reg[k]);
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in)
         high_reg <= '0;
      else
         high_reg <= high_next;
   end

   assign servo_gen_high_a = high_reg[0];
   assign servo_out_ch_b   = high_reg[1];
   assign servo_out_ch_c   = high_reg[2];
endmodule

// >>> spio_chk.sv
// Port-level checks for the servo pulse I/O block
`timescale 1ns/100ps
module spio_chk
   import spio_pkg::*;
(
   // Clock and reset
   input  wire logic            clock_in,
   input  wire logic            rst_in,
   // Watched ports
   input  wire logic            radio_in_ch_a_in,
   input  wire spio_width_t     width_a_out,
   input  wire spio_width_t     cmd_width_out,
   input  wire logic [N_IN-1:0] capture_event_out,
   input  wire logic [N_IN-1:0] stale_out,
   input  wire logic            servo_gen_high_a,
   input  wire logic            servo_out_ch_b,
   input  wire logic            servo_out_ch_c
);
   localparam int FRAME_CYC = 1000000;
   logic [19:0] cyc_reg;
   logic [16:0] hi_reg;
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);
   // Saturates so the first-frame window never wraps
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in)
         cyc_reg <= '0;
      else if (cyc_reg != 20'hfffff)
         cyc_reg <= cyc_reg + 20'h1;
   end
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in)
         hi_reg <= '0;
      else if (!servo_gen_high_a)
         hi_reg <= '0;
      else
         hi_reg <= hi_reg + 17'h1;
   end
   sequence s_fall_a;
      $fell(radio_in_ch_a_in);
   endsequence
   chk_event_one_cycle: assert property ((capture_event_out & $past(capture_event_out)) == 4'h0)
      else $error("capture event longer than one cycle");
   chk_capture_latency: assert property (s_fall_a |-> ##[1:3] capture_event_out[0])
      else $error("no capture event after falling edge");
   chk_width_hold: assert property ($changed(width_a_out) |-> capture_event_out[0])
      else $error("width changed without capture");
   chk_cmd_hold: assert property ($changed(cmd_width_out) |-> capture_event_out[3])
      else $error("command width changed without capture");
   chk_reset_values: assert property ($fell(rst_in) |-> stale_out == 4'hf && !servo_gen_high_a)
      else $error("wrong values out of reset");
   chk_stale_clear: assert property (capture_event_out[0] |-> ##[0:1] !stale_out[0])
      else $error("stale flag kept after capture");
   chk_servo_same: assert property (cyc_reg < FRAME_CYC |->
      servo_gen_high_a == servo_out_ch_b && servo_out_ch_b == servo_out_ch_c)
      else $error("servo lines differ in first frame");
   chk_servo_width: assert property ($fell(servo_gen_high_a) |-> hi_reg >= 17'h09c18 && hi_reg <= 17'h138a8)
      else $error("servo pulse width out of range");
endmodule
bind spio_top spio_chk spio_chk_i (.*);

// >>> spio_radio_model.sv
// Receiver model: one pulse per channel of a commanded length
`timescale 1ns/100ps
module spio_radio_model (
   input  wire logic        clock_in,
   input  wire logic        fire_in,
   input  wire logic [16:0] len_in [4],
   output logic [3:0]       pin_out
);
   logic [16:0] left_reg [4] = '{default: 17'h0};
   initial pin_out = 4'h0;
   always @(posedge clock_in) begin
      for (int k = 0; k < 4; k++) begin
         if (fire_in) begin
            pin_out[k] <= 1'b1;
            left_reg[k] <= len_in[k] - 17'h1;
         end else if (left_reg[k] != 17'h0)
            left_reg[k] <= left_reg[k] - 17'h1;
         else
            pin_out[k] <= 1'b0;
      end
   end
endmodule

// >>> test_servo_pulse_io.sv
// Self-checking bench for the servo pulse I/O block
`timescale 1ns/100ps
module test_servo_pulse_io
   import spio_pkg::*;
;
   logic        clock_in = 0;
   logic        rst_in = 1;
   logic        manual = 0;
   logic        fire = 0;
   logic [16:0] len [4] = '{default: '0};
   logic [3:0]  pins;
   spio_width_t duty [3] = '{default: 16'h05dc};
   spio_width_t wid [4];
   logic [3:0]  ev;
   logic [3:0]  stale;
   logic        srv_a;
   logic [17:0] notes [$];
   int          miscompares = 0;
   int          num_checks = 0;
   int          n = 0;
   logic [31:0] seed = 32'h8df694f4;
   logic [15:0] u;

   always #12.5 clock_in = ~clock_in;

   spio_radio_model spio_radio_model_i (.clock_in(clock_in), .fire_in(fire), .len_in(len), .pin_out(pins));
   spio_top spio_top_i (.clock_in(clock_in), .rst_in(rst_in), .radio_in_ch_a_in(pins[0]),
      .radio_in_ch_b_in(pins[1]), .radio_in_ch_c_in(pins[2]), .radio_cmd_in(pins[3]),
      .manual_mode_in(manual), .duty_a_in(duty[0]), .duty_b_in(duty[1]), .duty_c_in(duty[2]),
      .width_a_out(wid[0]), .width_b_out(wid[1]), .width_c_out(wid[2]), .cmd_width_out(wid[3]),
      .capture_event_out(ev), .stale_out(stale), .servo_gen_high_a(srv_a), .servo_out_ch_b(),
      .servo_out_ch_c());

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic check(input logic [16:0] seen, input logic [16:0] exp, input int tol);
      num_checks++;
      if (!(((seen + tol >= exp) && (seen <= exp + tol)) === 1'b1)) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      if (miscompares == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Each event takes the oldest note; widths are spread so they finish in order
   // Sampled mid-cycle, away from the edge that launches the outputs
   always @(negedge clock_in) begin
      for (int k = 0; k < 4; k++) begin
         if (ev[k] === 1'b1) begin
            if (notes.size() == 0) begin
               check(17'(notes.size()), 17'h1, 0);
            end else begin
               check(17'(k), 17'(notes[0][17:16]), 0);
               check(17'(wid[k]), 17'(notes[0][15:0]), 1);
               void'(notes.pop_front());
            end
         end
      end
   end

   initial begin
      #(95000 * 25);
      miscompares++;
      test_done();
   end

   initial begin
      repeat (5) @(posedge clock_in);
      rst_in <= 1'b0;
      @(posedge clock_in);
      manual <= 1'(rnd() % 2);
      for (int k = 0; k < 3; k++)
         duty[k] <= 16'(1000 + rnd() % 1001);
      for (int k = 0; k < 4; k++) begin
         u = 16'(1000 + 250 * k + rnd() % 200);
         len[k] <= 17'(u * 40);
         notes.push_back({2'(k), u});
      end
      fire <= 1'b1;
      @(posedge clock_in);
      fire <= 1'b0;
      // Servo duty stays at its reset width until the first frame ends
      while (n < 90000 && !(n > 100 && srv_a === 1'b0)) begin
         @(posedge clock_in);
         n++;
      end
      check(17'(n / 40), 17'(WIDTH_RST), 2);
      n = 0;
      while (n < 30000 && notes.size() > 0) begin
         @(posedge clock_in);
         n++;
      end
      check(17'(notes.size()), 17'h0, 0);
      check(17'(stale), 17'h0, 0);
      test_done();
   end
endmodule
